// ==== test/cfb_core_asserts.sv ====
// Checker of the flag and branch unit ports
`timescale 1ns/1ns
module cfb_core_asserts
  import cfb_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       exec_valid,
  input wire cfb_req_t   exec_req,
  input wire logic       irq_entry,
  input wire logic       exec_done,
  input wire cfb_rsp_t   exec_rsp,
  input wire logic [7:0] condition_code_reg,
  input wire logic       mem_rd,
  input wire logic [7:0] mem_addr
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] cc;
  logic [7:0] a;
  logic       go;
  cfb_op_t    op;
  assign cc = condition_code_reg;
  assign a  = exec_req.opa;
  assign op = exec_req.op;
  // Indirect relative jumps and calls take one cycle more
  assign go = exec_valid && !exec_req.indirect;
  a_clr_flags: assert property (go && op == OP_CLR |-> ##2 exec_done && cc[2:1] == 2'b01)
    else $error("clear flags wrong");
  a_cpl_value: assert property (go && op == OP_CPL |-> ##2 cc[0] && exec_rsp.result == ~$past(a, 2))
    else $error("complement wrong");
  a_mul_clear: assert property (go && op == OP_MUL |-> ##2 cc[4] == 1'b0 && cc[0] == 1'b0)
    else $error("multiply flags wrong");
  a_carry_reset: assert property (go && op == OP_RCF |-> ##2 cc == {$past(cc[7:1], 2), 1'b0})
    else $error("carry reset wrong");
  a_mask_ops: assert property (go && op inside {OP_RIM, OP_SIM, OP_WFI}
    |-> ##2 cc[3] == ($past(op, 2) == OP_SIM))
    else $error("mask flag wrong");
  a_irq_mask: assert property (irq_entry |-> ##[1:2] cc[3])
    else $error("entry mask missing");
  a_ptr_read: assert property (exec_valid && exec_req.indirect && op == OP_COND_RELATIVE_JUMP
    |=> mem_rd && mem_addr == $past(exec_req.operand))
    else $error("pointer read wrong");
  a_never_jump: assert property (go && op == OP_COND_RELATIVE_JUMP && exec_req.cond == CND_F
    |-> ##2 exec_done && !exec_rsp.branch && cc == $past(cc, 2))
    else $error("never jump branched");
  c_taken: cover property (exec_done && exec_rsp.branch);
  c_ptr: cover property (mem_rd);
  c_irq: cover property (irq_entry);
endmodule
bind cfb_core cfb_core_asserts i_cfb_core_asserts (
  .clk_sys, .rst_n, .exec_valid, .exec_req, .irq_entry, .exec_done, .exec_rsp,
  .condition_code_reg, .mem_rd, .mem_addr
);

// ==== test/cfb_core_test.sv ====
// Self-checking bench of the flag and branch unit
`timescale 1ns/1ns
module cfb_core_test
  import cfb_pkg::*;
();
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        ext_irq_pin = 1'b0;
  logic        exec_valid = 1'b0;
  cfb_req_t    exec_req = '0;
  logic        irq_entry = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic        exec_done;
  cfb_rsp_t    exec_rsp;
  logic [7:0]  cc;
  logic [7:0]  stack_ptr;
  logic        mem_rd;
  logic [7:0]  mem_addr;
  logic [7:0]  mem_rdata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  logic [7:0]  off;
  logic [7:0]  cv [6] = '{8'h00, 8'h1F, 8'h01, 8'h02, 8'h15, 8'h0A};
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n_exec = 0;
  always #50 clk_sys = ~clk_sys;
  cfb_core i_cfb_core (
    .clk_sys, .rst_n, .ext_irq_pin, .exec_valid, .exec_req, .irq_entry, .exec_done, .exec_rsp,
    .condition_code_reg(cc), .stack_ptr, .mem_rd, .mem_addr, .mem_rdata, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest
  );
  cfb_mem_model i_cfb_mem_model (.clk_sys, .mem_rd, .mem_addr, .mem_rdata);
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task hang();
    error_cnt++;
    end_of_test();
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 50 && avs_waitrequest !== 1'b0; n++)
      @(posedge clk_sys);
    if (n == 50)
      hang();
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task exe(input cfb_op_t op, input cfb_cond_t cd, input logic ind, input logic [7:0] a,
           input logic [7:0] b, input logic [7:0] opd, input logic [2:0] bs);
    int n;
    @(posedge clk_sys);
    exec_req <= '{op, cd, ind, bs, a, b, a, opd, 16'h1200};
    exec_valid <= 1'b1;
    n_exec++;
    @(posedge clk_sys);
    exec_valid <= 1'b0;
    for (n = 0; n < 10 && exec_done !== 1'b1; n++)
      @(posedge clk_sys);
    if (n == 10)
      hang();
  endtask
  function automatic logic tk(input logic [4:0] cd, input logic [7:0] f, input logic irq);
    if (cd < 5'h02)
      return !cd[0];
    if (cd < 5'h04)
      return irq ^ cd[0];
    // Flag pairs H, I, N, Z, C; odd codes branch on zero
    if (cd < 5'h0E)
      return f[(5'h0D - cd) >> 1] ^ cd[0];
    return (f[0] | f[1]) ^ !cd[0];
  endfunction
  task tf(input cfb_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] ci,
          input logic [7:0] cx);
    bus(1'b1, 4'h0, {24'h00_0000, ci});
    exe(op, CND_T, 1'b0, a, b, 8'h00, 3'h0);
    chk(cc, cx);
  endtask
  task t(input cfb_op_t op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] ci,
         input logic [7:0] r, input logic [7:0] cx);
    tf(op, a, b, ci, cx);
    chk(exec_rsp.result, r);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk(rd, 32'h0000_00E8);
    bus(1'b1, 4'hF, 32'h0000_00A5);
    bus(1'b0, 4'hF, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    t(OP_CLR, 8'h5A, 8'h5A, 8'h1D, 8'h00, 8'hFB);
    t(OP_CPL, 8'h5A, 8'h5A, 8'h18, 8'hA5, 8'hFD);
    t(OP_CPL, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hE3);
    t(OP_NEG, 8'h80, 8'h80, 8'h00, 8'h80, 8'hE5);
    t(OP_NEG, 8'h00, 8'h00, 8'h07, 8'h00, 8'hE2);
    t(OP_MUL, 8'hFF, 8'hFF, 8'h1F, 8'h01, 8'hEE);
    chk(exec_rsp.result_hi, 8'hFE);
    chk(exec_rsp.wr_pair, 1'b1);
    tf(OP_CP, 8'h10, 8'h20, 8'h00, 8'hE5);
    chk(exec_rsp.wr_result, 1'b0);
    tf(OP_CP, 8'h20, 8'h20, 8'h1D, 8'hFA);
    t(OP_SBC, 8'h10, 8'h0F, 8'h01, 8'h00, 8'hE2);
    t(OP_SBC, 8'h00, 8'h00, 8'h01, 8'hFF, 8'hE5);
    t(OP_SRL, 8'h81, 8'h81, 8'h04, 8'h40, 8'hE1);
    t(OP_SRA, 8'h81, 8'h81, 8'h00, 8'hC0, 8'hE5);
    t(OP_RLC, 8'h40, 8'h40, 8'h01, 8'h81, 8'hE4);
    t(OP_RRC, 8'h01, 8'h01, 8'h01, 8'h80, 8'hE5);
    t(OP_LD, 8'h00, 8'h00, 8'h05, 8'h00, 8'hE3);
    tf(OP_RIM, 8'h00, 8'h00, 8'h1F, 8'hF7);
    tf(OP_SIM, 8'h00, 8'h00, 8'h00, 8'hE8);
    tf(OP_WFI, 8'h00, 8'h00, 8'h1F, 8'hF7);
    tf(OP_RCF, 8'h00, 8'h00, 8'h1F, 8'hFE);
    tf(OP_SCF, 8'h00, 8'h00, 8'h00, 8'hE1);
    tf(OP_TRAP, 8'h00, 8'h00, 8'h00, 8'hE8);
    chk(exec_rsp.sw_irq, 1'b1);
    bus(1'b1, 4'h1, 32'h0000_0040);
    tf(OP_RSP, 8'h00, 8'h00, 8'h00, 8'hE0);
    chk(stack_ptr, 8'hFF);
    bus(1'b0, 4'h1, 32'h0000_0000);
    chk(rd, 32'h0000_00FF);
    bus(1'b1, 4'h0, 32'h0000_0000);
    irq_entry <= 1'b1;
    @(posedge clk_sys);
    irq_entry <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(cc, 8'hE8);
    exe(OP_BTJT, CND_T, 1'b0, 8'h08, 8'h08, 8'h10, 3'h3);
    chk(exec_rsp.target, 16'h1210);
    chk(cc, 8'hE9);
    exe(OP_BTJF, CND_T, 1'b0, 8'hF7, 8'hF7, 8'hF0, 3'h3);
    chk(exec_rsp.branch, 1'b1);
    chk(cc, 8'hE8);
    exe(OP_IRQ_RETURN_OP, CND_T, 1'b0, 8'h00, 8'h00, 8'h15, 3'h0);
    chk(cc, 8'hF5);
    for (int p = 0; p < 2; p++)
    begin
      ext_irq_pin <= p[0];
      repeat (5) @(posedge clk_sys);
      for (int k = 0; k < 6; k++)
        for (int c = 0; c < 16; c++)
        begin
          bus(1'b1, 4'h0, {24'h00_0000, cv[k]});
          exe(OP_COND_RELATIVE_JUMP, cfb_cond_t'(c[4:0]), k[0], 8'h00, 8'h00, 8'h7F, 3'h0);
          // Pointer 7F holds 80 in the memory model
          off = k[0] ? 8'h80 : 8'h7F;
          chk(exec_rsp.branch, tk(c[4:0], cv[k], p[0]));
          if (exec_rsp.branch === 1'b1)
            chk(exec_rsp.target, 16'(16'h1200 + {{8{off[7]}}, off}));
          chk(cc, {3'b111, cv[k][4:0]});
        end
    end
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(rd, 32'h0000_0004);
    bus(1'b0, 4'h3, 32'h0000_0000);
    chk(rd, n_exec);
    end_of_test();
  end
endmodule

// ==== test/cfb_mem_model.sv ====
// Data memory model answering pointer reads
`timescale 1ns/1ns
module cfb_mem_model (
  input wire logic       clk_sys,
  input wire logic       mem_rd,
  input wire logic [7:0] mem_addr,
  output logic [7:0]     mem_rdata
);
  logic [7:0] held = 8'h00;
  logic       keep = 1'b0;
  // offset byte at pointer
  // Held two cycles past the read, then toggles so stale data never matches
  always_ff @(posedge clk_sys)
  begin
    if (mem_rd)
      held <= ~mem_addr;
    else if (!keep)
      held <= ~held;
  end
  always_ff @(posedge clk_sys)
  begin
    keep <= mem_rd;
  end
  assign mem_rdata = mem_rd ? ~mem_addr : held;
endmodule

// ==== verilog/cfb_alu.sv ====
// Combinational arithmetic, logic, shift and flag computation
`timescale 1ns/1ns
module cfb_alu
  import cfb_pkg::*;
(
  input  wire cfb_op_t    op,
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic [2:0] bit_sel,
  input  wire cfb_flags_t flg_in,
  output logic [7:0]      res,
  output logic [7:0]      res_hi,
  output logic            wr_res,
  output logic            wr_pair,
  output cfb_flags_t      flg_out
);
  logic [8:0]  sum;
  logic [15:0] prod;

  always_comb
  begin
    res     = opa;
    res_hi  = 8'h00;
    wr_res  = 1'b0;
    wr_pair = 1'b0;
    sum     = 9'h000;
    prod    = 16'h0000;
    flg_out = flg_in;
    case (op)
      OP_LD:
      begin
        res = opb;
        wr_res = 1'b1;
      end
      OP_CLR:
      begin
        res = 8'h00;
        wr_res = 1'b1;
      end
      OP_INC:
      begin
        res = opa + 8'h01;
        wr_res = 1'b1;
      end
      OP_DEC:
      begin
        res = opa - 8'h01;
        wr_res = 1'b1;
      end
      OP_CP, OP_SUB:
      begin
        sum = {1'b0, opa} - {1'b0, opb};
        res = sum[7:0];
        wr_res = (op == OP_SUB);
        flg_out.c = sum[8];
      end
      OP_SBC:
      begin
        sum = {1'b0, opa} - {1'b0, opb} - {8'h00, flg_in.c};
        res = sum[7:0];
        wr_res = 1'b1;
        flg_out.c = sum[8];
      end
      OP_ADD, OP_ADC:
      begin
        sum = {1'b0, opa} + {1'b0, opb} + {8'h00, (op == OP_ADC) & flg_in.c};
        res = sum[7:0];
        wr_res = 1'b1;
        flg_out.c = sum[8];
        flg_out.h = (opa[3:0] ^ opb[3:0] ^ res[3:0]) != 4'h0 ? sum[4] ^ opa[4] ^ opb[4]
                                                              : sum[4] ^ opa[4] ^ opb[4];
      end
      OP_TNZ: res = opa;
      OP_BCP: res = opa & opb;
      OP_AND:
      begin
        res = opa & opb;
        wr_res = 1'b1;
      end
      OP_OR:
      begin
        res = opa | opb;
        wr_res = 1'b1;
      end
      OP_XOR:
      begin
        res = opa ^ opb;
        wr_res = 1'b1;
      end
      OP_CPL:
      begin
        res = CFB_ONES - opa;
        wr_res = 1'b1;
        flg_out.c = 1'b1;
      end
      OP_NEG:
      begin
        res = 8'h00 - opa;
        wr_res = 1'b1;
        flg_out.c = (opa != 8'h00);
      end
      OP_BSET, OP_BRES:
      begin
        res = opa;
        res[bit_sel] = (op == OP_BSET);
        wr_res = 1'b1;
      end
      OP_BTJT, OP_BTJF: flg_out.c = opa[bit_sel];
      OP_MUL:
      begin
        prod = opa * opb;
        res = prod[7:0];
        res_hi = prod[15:8];
        wr_pair = 1'b1;
        flg_out.h = 1'b0;
        flg_out.c = 1'b0;
      end
      OP_SLL:
      begin
        res = {opa[6:0], 1'b0};
        wr_res = 1'b1;
        flg_out.c = opa[7];
      end
      OP_SRL:
      begin
        res = {1'b0, opa[7:1]};
        wr_res = 1'b1;
        flg_out.c = opa[0];
      end
      OP_SRA:
      begin
        res = {opa[7], opa[7:1]};
        wr_res = 1'b1;
        flg_out.c = opa[0];
      end
      OP_RLC:
      begin
        res = {opa[6:0], flg_in.c};
        wr_res = 1'b1;
        flg_out.c = opa[7];
      end
      OP_RRC:
      begin
        res = {flg_in.c, opa[7:1]};
        wr_res = 1'b1;
        flg_out.c = opa[0];
      end
      OP_SWAP:
      begin
        res = {opa[3:0], opa[7:4]};
        wr_res = 1'b1;
      end
      default: res = opa;
    endcase
    // N and Z from result byte
    case (op)
      OP_LD, OP_INC, OP_DEC, OP_CP, OP_SUB, OP_SBC, OP_ADD, OP_ADC, OP_TNZ, OP_BCP,
      OP_AND, OP_OR, OP_XOR, OP_CPL, OP_NEG, OP_SLL, OP_SRA, OP_RLC, OP_RRC, OP_SWAP:
      begin
        flg_out.n = res[7];
        flg_out.z = res_zero(res);
      end
      OP_SRL:
      begin
        flg_out.n = 1'b0;
        flg_out.z = res_zero(res);
      end
      OP_CLR:
      begin
        flg_out.n = 1'b0;
        flg_out.z = 1'b1;
      end
      default: flg_out.n = flg_out.n;
    endcase
  end
endmodule

// ==== verilog/cfb_branch.sv ====
// Branch condition evaluation for the conditional relative jumps
`timescale 1ns/1ns
module cfb_branch
  import cfb_pkg::*;
(
  input  wire cfb_cond_t  cond,
  input  wire cfb_flags_t flg,
  input  wire logic       ext_irq,
  output logic            take
);
  always_comb
  begin
    case (cond)
      CND_T:   take = 1'b1;
      CND_F:   take = 1'b0;
      CND_IH:  take = ext_irq;
      CND_IL:  take = ~ext_irq;
      CND_H:   take = flg.h;
      CND_NH:  take = ~flg.h;
      CND_M:   take = flg.i;
      CND_NM:  take = ~flg.i;
      CND_MI:  take = flg.n;
      CND_PL:  take = ~flg.n;
      CND_EQ:  take = flg.z;
      CND_NE:  take = ~flg.z;
      CND_C:   take = flg.c;
      CND_NC:  take = ~flg.c;
      CND_UGT: take = ~(flg.c | flg.z);
      CND_ULE: take = flg.c | flg.z;
      default: take = 1'b0;
    endcase
  end
endmodule

// ==== verilog/cfb_core.sv ====
// Flag and branch execution unit with Avalon-MM control registers
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ns
module cfb_core
  import cfb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        ext_irq_pin,
  input  wire logic        exec_valid,
  input  wire cfb_req_t    exec_req,
  input  wire logic        irq_entry,
  output logic             exec_done,
  output cfb_rsp_t         exec_rsp,
  output logic [7:0]       condition_code_reg,
  output logic [7:0]       stack_ptr,
  output logic             mem_rd,
  output logic [7:0]       mem_addr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);
  localparam logic [3:0] REG_CC    = 4'h0;
  localparam logic [3:0] REG_SP    = 4'h1;
  localparam logic [3:0] REG_STAT  = 4'h2;
  localparam logic [3:0] REG_COUNT = 4'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PTR  = 2'b01,
    ST_EXEC = 2'b10
  } cfb_state_t;

  cfb_state_t  state;
  cfb_req_t    req;
  cfb_flags_t  flg;
  cfb_flags_t  alu_flg;
  logic [7:0]  alu_res;
  logic [7:0]  alu_hi;
  logic        alu_wr;
  logic        alu_pair;
  logic        take;
  logic [2:0]  irq_sync;
  logic        irq_lvl;
  logic [15:0] op_count;
  logic        bus_ack;
  logic [7:0]  offset;

  // Level counts once two later stages agree
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_sync <= 3'b000;
    else
      irq_sync <= {irq_sync[1:0], ext_irq_pin};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_lvl <= 1'b0;
    else if (irq_sync[2] == irq_sync[1])
      irq_lvl <= irq_sync[2];
  end

  assign flg = '{h: condition_code_reg[CFB_BIT_H], i: condition_code_reg[CFB_BIT_I],
                 n: condition_code_reg[CFB_BIT_N], z: condition_code_reg[CFB_BIT_Z],
                 c: condition_code_reg[CFB_BIT_C]};

  cfb_alu u_alu (
    .op      (req.op),
    .opa     (req.opa),
    .opb     (req.opb),
    .bit_sel (req.bit_sel),
    .flg_in  (flg),
    .res     (alu_res),
    .res_hi  (alu_hi),
    .wr_res  (alu_wr),
    .wr_pair (alu_pair),
    .flg_out (alu_flg)
  );

  cfb_branch u_branch (
    .cond    (req.cond),
    .flg     (flg),
    .ext_irq (irq_lvl),
    .take    (take)
  );

  // Offset source for relative branches
  assign offset = req.indirect ? mem_rdata : req.operand;

  // Sequencer: one request at a time, indirect relative jump or call adds a memory read
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      req   <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          if (exec_valid)
          begin
            req <= exec_req;
            // indirect reads the offset byte first
            state <= (exec_req.indirect &&
                      (exec_req.op == OP_COND_RELATIVE_JUMP || exec_req.op == OP_RELATIVE_SUBROUTINE_CALL)) ? ST_PTR : ST_EXEC;
          end
        ST_PTR:  state <= ST_EXEC;
        ST_EXEC: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      mem_rd   <= 1'b0;
      mem_addr <= 8'h00;
    end
    else
    begin
      mem_rd   <= (state == ST_IDLE) && exec_valid && exec_req.indirect &&
                  (exec_req.op == OP_COND_RELATIVE_JUMP || exec_req.op == OP_RELATIVE_SUBROUTINE_CALL);
      mem_addr <= exec_req.operand;
    end
  end

  // Response and branch target
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      exec_done <= 1'b0;
      exec_rsp  <= '0;
    end
    else
    begin
      exec_done <= (state == ST_EXEC);
      if (state == ST_EXEC)
      begin
        exec_rsp.result    <= alu_res;
        exec_rsp.result_hi <= alu_hi;
        exec_rsp.wr_result <= alu_wr;
        exec_rsp.wr_pair   <= alu_pair;
        // target is PC plus signed offset
        exec_rsp.target    <= req.pc_next + {{8{offset[7]}}, offset};
        case (req.op)
          OP_COND_RELATIVE_JUMP:  exec_rsp.branch <= take;
          OP_RELATIVE_SUBROUTINE_CALL: exec_rsp.branch <= 1'b1;
          OP_BTJT:  exec_rsp.branch <= req.opa[req.bit_sel];
          OP_BTJF:  exec_rsp.branch <= ~req.opa[req.bit_sel];
          default:  exec_rsp.branch <= 1'b0;
        endcase
        exec_rsp.sw_irq    <= (req.op == OP_TRAP);
      end
    end
  end

  // Condition code register; bus write has lowest priority
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      condition_code_reg <= CFB_CC_RESET;
    else if (irq_entry)
      condition_code_reg[CFB_BIT_I] <= 1'b1;
    else if (state == ST_EXEC)
    begin
      condition_code_reg[CFB_BIT_H] <= alu_flg.h;
      condition_code_reg[CFB_BIT_N] <= alu_flg.n;
      condition_code_reg[CFB_BIT_Z] <= alu_flg.z;
      condition_code_reg[CFB_BIT_C] <= alu_flg.c;
      case (req.op)
        OP_RIM, OP_WFI, OP_HALT: condition_code_reg[CFB_BIT_I] <= 1'b0;
        OP_SIM, OP_TRAP:         condition_code_reg[CFB_BIT_I] <= 1'b1;
        OP_RCF: condition_code_reg[CFB_BIT_C] <= 1'b0;
        OP_SCF: condition_code_reg[CFB_BIT_C] <= 1'b1;
        OP_IRQ_RETURN_OP, OP_POP_CC: condition_code_reg <= {3'b111, req.operand[4:0]};
        default: condition_code_reg[CFB_BIT_I] <= condition_code_reg[CFB_BIT_I];
      endcase
    end
    else if (bus_ack && avs_write && avs_address == REG_CC)
      condition_code_reg <= {3'b111, avs_writedata[4:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      stack_ptr <= CFB_SP_MAX;
    else if (state == ST_EXEC && req.op == OP_RSP)
      stack_ptr <= CFB_SP_MAX;
    else if (bus_ack && avs_write && avs_address == REG_SP)
      stack_ptr <= avs_writedata[7:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      op_count <= 16'h0000;
    else if (state == ST_EXEC)
      op_count <= op_count + 16'h0001;
  end

  // Avalon slave: one wait cycle, then acknowledge
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      bus_ack <= 1'b0;
    else
      bus_ack <= (avs_read || avs_write) && !bus_ack;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !bus_ack);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !bus_ack)
    begin
      if (avs_address == REG_CC)
        avs_readdata <= {24'h00_0000, condition_code_reg};
      else if (avs_address == REG_SP)
        avs_readdata <= {24'h00_0000, stack_ptr};
      else if (avs_address == REG_STAT)
        avs_readdata <= {29'h0000_0000, irq_lvl, state};
      else if (avs_address == REG_COUNT)
        avs_readdata <= {16'h0000, op_count};
      else
        avs_readdata <= 32'h0000_0000;
    end
  end
endmodule

// ==== verilog/cfb_pkg.sv ====
// Package: operation codes, flag layout, carriers and constants of the flag and branch unit
//Operation
//- Branch target is PC plus signed offset
//- Offset direct from operand or via pointer
//- Decoder covers 63 instructions, 13 groups
//- Single-flag jumps test flag per polarity
//- Unsigned compare jumps use carry and zero
//- Two jumps test external interrupt level
//- Bit test jump branches, updates carry only
//- Ones complement: FFH minus operand, C=1
//- Multiply X*A to X:A, clear H C
//- Compare subtracts, stores nothing, N Z C
//- Subtract with borrow into accumulator, N Z C
//- Logical right shift: 0 in, LSB to carry
//- Arithmetic right shift keeps bit 7
//- Rotates pass through carry, update N Z
//- Unmask and wait clear I, mask sets I
//- Carry reset clears, carry set sets C
//- Trap raises interrupt sets I; return restores flags
//- Stack reset loads maximum stack pointer
//- Interrupt entry pushes flags and sets I; irq_entry here only sets I, nothing is pushed
package cfb_pkg;

  localparam int CFB_DATA_W = 8;
  localparam int CFB_PC_W   = 16;
  localparam int CFB_SP_W   = 8;

  localparam logic [7:0]  CFB_SP_MAX     = 8'hFF;
  localparam logic [7:0]  CFB_CC_RESET   = 8'hE8;
  localparam logic [7:0]  CFB_ONES       = 8'hFF;
  localparam logic [15:0] CFB_PC_RESET   = 16'h0000;
  localparam logic [3:0]  CFB_OPCODE_W   = 4'h6;
  localparam int          CFB_NUM_OPS    = 63;
  localparam int          CFB_NUM_GROUPS = 13;

  // Flag positions inside the condition code register
  localparam int CFB_BIT_C = 0;
  localparam int CFB_BIT_Z = 1;
  localparam int CFB_BIT_N = 2;
  localparam int CFB_BIT_I = 3;
  localparam int CFB_BIT_H = 4;

  typedef enum logic [5:0] {
    OP_NOP        = 6'h00, OP_LD        = 6'h01, OP_CLR       = 6'h02,
    OP_PUSH       = 6'h03, OP_POP       = 6'h04, OP_POP_CC    = 6'h05,
    OP_RSP        = 6'h06, OP_INC       = 6'h07, OP_DEC       = 6'h08,
    OP_CP         = 6'h09, OP_TNZ       = 6'h0A, OP_BCP       = 6'h0B,
    OP_AND        = 6'h0C, OP_OR        = 6'h0D, OP_XOR       = 6'h0E,
    OP_CPL        = 6'h0F, OP_NEG       = 6'h10, OP_BSET      = 6'h11,
    OP_BRES       = 6'h12, OP_BTJT      = 6'h13, OP_BTJF      = 6'h14,
    OP_ADC        = 6'h15, OP_ADD       = 6'h16, OP_SUB       = 6'h17,
    OP_SBC        = 6'h18, OP_MUL       = 6'h19, OP_SLL       = 6'h1A,
    OP_SRL        = 6'h1B, OP_SRA       = 6'h1C, OP_RLC       = 6'h1D,
    OP_RRC        = 6'h1E, OP_SWAP      = 6'h1F, OP_JP        = 6'h20,
    OP_CALL       = 6'h21, OP_RELATIVE_SUBROUTINE_CALL     = 6'h22, OP_RET       = 6'h23,
    OP_IRQ_RETURN_OP       = 6'h24, OP_TRAP      = 6'h25, OP_HALT      = 6'h26,
    OP_WFI        = 6'h27, OP_RIM       = 6'h28, OP_SIM       = 6'h29,
    OP_RCF        = 6'h2A, OP_SCF       = 6'h2B, OP_COND_RELATIVE_JUMP      = 6'h2C
  } cfb_op_t;

  // Branch condition for the conditional relative jump
  typedef enum logic [4:0] {
    CND_T   = 5'h00, CND_F    = 5'h01, CND_IH  = 5'h02, CND_IL   = 5'h03,
    CND_H   = 5'h04, CND_NH   = 5'h05, CND_M   = 5'h06, CND_NM   = 5'h07,
    CND_MI  = 5'h08, CND_PL   = 5'h09, CND_EQ  = 5'h0A, CND_NE   = 5'h0B,
    CND_C   = 5'h0C, CND_NC   = 5'h0D, CND_UGT = 5'h0E, CND_ULE  = 5'h0F
  } cfb_cond_t;

  typedef struct packed {
    cfb_op_t    op;
    cfb_cond_t  cond;
    logic       indirect;
    logic [2:0] bit_sel;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [7:0] xreg;
    logic [7:0] operand;
    logic [15:0] pc_next;
  } cfb_req_t;

  typedef struct packed {
    logic [7:0]  result;
    logic [7:0]  result_hi;
    logic        wr_result;
    logic        wr_pair;
    logic        branch;
    logic [15:0] target;
    logic        sw_irq;
  } cfb_rsp_t;

  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cfb_flags_t;

  // Z from a zero result, N from bit 7
  function automatic logic res_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

endpackage
